// ==== hdl/sfp_pkg.sv ====
`default_nettype none
package sfp_pkg;

  // ==========================================================================
  // Array geometry
  localparam int          ADDR_W     = 20;
  localparam int          PAGE_BYTES = 256;
  localparam logic [19:0] ADDR_TOP   = 20'hFFFFF;
  localparam logic [8:0]  PAGE_FULL  = 9'h100;

  // ==========================================================================
  // Opcodes
  localparam logic [7:0] OP_READ_FAST  = 8'h0B;
  localparam logic [7:0] OP_READ_SLOW  = 8'h03;
  localparam logic [7:0] OP_PAGE_PROG  = 8'h02;
  localparam logic [7:0] OP_WREN       = 8'h06;
  localparam logic [7:0] OP_WRDI       = 8'h04;
  localparam logic [7:0] OP_ERASE_4K   = 8'h20;
  localparam logic [7:0] OP_ERASE_32K  = 8'h52;
  localparam logic [7:0] OP_ERASE_64K  = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERA_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERA_B = 8'hC7;
  localparam logic [7:0] OP_SEQ_A      = 8'hAD;
  localparam logic [7:0] OP_SEQ_B      = 8'hAF;
  localparam logic [7:0] OP_PROTECT    = 8'h36;
  localparam logic [7:0] OP_UNPROTECT  = 8'h39;
  localparam logic [7:0] OP_PROT_READ  = 8'h3C;
  localparam logic [7:0] OP_STATUS_RD  = 8'h05;
  localparam logic [7:0] OP_STATUS_WR  = 8'h01;
  localparam logic [7:0] OP_ID_READ    = 8'h9F;
  localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
  localparam logic [7:0] OP_RESUME     = 8'hAB;

  // ==========================================================================
  // Status byte layout and reset values
  localparam int         ST_BUSY_BIT  = 0;
  localparam int         ST_LATCH_BIT = 1;
  localparam int         ST_ERROR_BIT = 5;
  localparam logic [2:0] PIN_RESET    = 3'h4;

  // ==========================================================================
  // Timing
  localparam int REF_CLK_MHZ          = 200;
  localparam int PAGE_PROGRAM_TIME_NS = 1000;
  localparam int PAGE_PROGRAM_CYCLES  = (PAGE_PROGRAM_TIME_NS * REF_CLK_MHZ + 999) / 1000;

endpackage
`default_nettype wire

// ==== hdl/sfp_port.sv ====
`timescale 1ns/100ps
`default_nettype none
module sfp_port #(
  parameter int PROG_WAIT_CYCLES = sfp_pkg::PAGE_PROGRAM_CYCLES
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Serial link pins
  input  wire logic        csN,
  input  wire logic        sck,
  input  wire logic        si,
  output logic             so,
  output logic             soOe,
  // Memory array
  output logic [19:0]      memAddr,
  input  wire logic [7:0]  memRdData,
  output logic             memWrEn,
  output logic [7:0]       memWrData,
  input  wire logic        protHit,
  // Forwarded commands
  output logic             cmdStrobe,
  output logic [7:0]       cmdOpcode,
  output logic [19:0]      cmdAddr,
  output logic [7:0]       cmdData,
  // Status
  output logic             busy,
  output logic             writeLatchFlag,
  output logic             programErrorFlag,
  output logic             seqMode
);

  localparam int WAIT_W = $clog2(PROG_WAIT_CYCLES + 1);

  typedef enum logic [3:0] {
    S_OP, S_ADDR, S_DUMMY, S_RDATA, S_PDATA, S_STAT, S_ARG, S_DONE, S_IGN
  } sfp_state_t;

  typedef enum logic [2:0] {
    P_IDLE, P_WRITE, P_HOLD, P_SETTLE, P_CHECK, P_WAIT
  } sfp_eng_t;

  logic [2:0]        s1_q, s2_q, s3_q, f_q;
  logic [1:0]        prev_q;
  logic              csF, sckF, siF, csRise, sckRise, sckFall;
  sfp_state_t        state_q;
  sfp_eng_t          engState_q;
  logic [2:0]        bitIdx_q, outBit_q;
  logic [1:0]        addrCnt_q;
  logic [6:0]        inSh_q, outSh_q;
  logic [7:0]        byteIn, opcode_q, argData_q, statusByte, loadByte, bufIdx;
  logic [19:0]       addr_q;
  logic [8:0]        dataCnt_q, progLeft_q;
  logic [7:0]        wrIdx_q;
  logic              argGot_q, so_q, soOe_q, wel_q, err_q, seq_q;
  logic              byteDone, isProg, progStart, progAbort, cmdOk;
  logic [11:0]       page_q;
  logic [7:0]        progIdx_q;
  logic [WAIT_W-1:0] waitCnt_q;
  logic [19:0]       memAddr_q;
  logic              memWrEn_q, cmdStrobe_q;
  logic [7:0]        memWrData_q, cmdOpcode_q, cmdData_q;
  logic [19:0]       cmdAddr_q;
  logic [7:0]        pageBuf [sfp_pkg::PAGE_BYTES];

  function automatic sfp_state_t decodeOp(input logic [7:0] op, input logic b,
                                          input logic w, input logic sq);
    decodeOp = S_IGN;
    unique case (op)
      sfp_pkg::OP_READ_FAST, sfp_pkg::OP_READ_SLOW, sfp_pkg::OP_PROTECT,
      sfp_pkg::OP_UNPROTECT, sfp_pkg::OP_PROT_READ: begin
        if (!b) decodeOp = S_ADDR;
      end
      sfp_pkg::OP_PAGE_PROG, sfp_pkg::OP_ERASE_4K, sfp_pkg::OP_ERASE_32K,
      sfp_pkg::OP_ERASE_64K: begin
        if (!b && w) decodeOp = S_ADDR;
      end
      sfp_pkg::OP_SEQ_A, sfp_pkg::OP_SEQ_B: begin
        if (!b && (w || sq)) decodeOp = sq ? S_ARG : S_ADDR;
      end
      sfp_pkg::OP_CHIP_ERA_A, sfp_pkg::OP_CHIP_ERA_B: begin
        if (!b && w) decodeOp = S_DONE;
      end
      sfp_pkg::OP_WREN, sfp_pkg::OP_WRDI, sfp_pkg::OP_ID_READ,
      sfp_pkg::OP_POWER_DOWN, sfp_pkg::OP_RESUME: begin
        if (!b) decodeOp = S_DONE;
      end
      sfp_pkg::OP_STATUS_WR: begin
        if (!b) decodeOp = S_ARG;
      end
      sfp_pkg::OP_STATUS_RD: decodeOp = S_STAT;
      default: decodeOp = S_IGN;
    endcase
  endfunction

  function automatic sfp_state_t afterAddr(input logic [7:0] op);
    afterAddr = S_DONE;
    unique case (op)
      sfp_pkg::OP_READ_FAST: afterAddr = S_DUMMY;
      sfp_pkg::OP_READ_SLOW: afterAddr = S_RDATA;
      sfp_pkg::OP_PAGE_PROG: afterAddr = S_PDATA;
      sfp_pkg::OP_SEQ_A, sfp_pkg::OP_SEQ_B: afterAddr = S_ARG;
      default: afterAddr = S_DONE;
    endcase
  endfunction

  // ==========================================================================
  // Pin synchronisers
  // A filtered bit follows only when the second and third stages agree, so a
  // single-cycle glitch on a pin never becomes a clock edge.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s1_q   <= sfp_pkg::PIN_RESET;
      s2_q   <= sfp_pkg::PIN_RESET;
      s3_q   <= sfp_pkg::PIN_RESET;
      f_q    <= sfp_pkg::PIN_RESET;
      prev_q <= 2'h2;
    end else begin
      s1_q   <= {csN, sck, si};
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      f_q    <= (s2_q & s3_q) | (f_q & (s2_q | s3_q));
      prev_q <= f_q[2:1];
    end
  end

  assign csF      = f_q[2];
  assign sckF     = f_q[1];
  assign siF      = f_q[0];
  assign csRise   = csF & ~prev_q[1];
  assign sckRise  = sckF & ~prev_q[0] & ~csF;
  assign sckFall  = ~sckF & prev_q[0] & ~csF;
  assign byteIn   = {inSh_q, siF};
  assign byteDone = sckRise && (bitIdx_q == 3'h7);
  assign busy     = (engState_q != P_IDLE);
  assign bufIdx   = addr_q[7:0] + wrIdx_q;
  assign isProg   = (opcode_q == sfp_pkg::OP_PAGE_PROG);

  // Start only with address, at least one whole byte and a clean byte edge.
  assign progStart = csRise && isProg && (state_q == S_PDATA) && (dataCnt_q != 9'h000)
                     && (bitIdx_q == 3'h0) && !protHit;
  assign progAbort = csRise && isProg && (state_q == S_ADDR || state_q == S_PDATA)
                     && !progStart;
  assign cmdOk     = csRise && (bitIdx_q == 3'h0)
                     && (state_q == S_DONE || (state_q == S_ARG && argGot_q));

  always_comb begin
    statusByte                        = 8'h00;
    statusByte[sfp_pkg::ST_BUSY_BIT]  = busy;
    statusByte[sfp_pkg::ST_LATCH_BIT] = wel_q;
    statusByte[sfp_pkg::ST_ERROR_BIT] = err_q;
    loadByte = (state_q == S_RDATA) ? memRdData : statusByte;
  end

  // ==========================================================================
  // Command sequencer and serial output
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q   <= S_OP;
      bitIdx_q  <= 3'h0;
      outBit_q  <= 3'h0;
      addrCnt_q <= 2'h0;
      inSh_q    <= 7'h00;
      outSh_q   <= 7'h00;
      opcode_q  <= 8'h00;
      argData_q <= 8'h00;
      addr_q    <= 20'h00000;
      dataCnt_q <= 9'h000;
      wrIdx_q   <= 8'h00;
      argGot_q  <= 1'b0;
      so_q      <= 1'b0;
    end else if (csF) begin
      state_q   <= S_OP;
      bitIdx_q  <= 3'h0;
      outBit_q  <= 3'h0;
      addrCnt_q <= 2'h0;
      dataCnt_q <= 9'h000;
      wrIdx_q   <= 8'h00;
      argGot_q  <= 1'b0;
    end else if (sckRise) begin
      inSh_q   <= byteIn[6:0];
      bitIdx_q <= bitIdx_q + 3'h1;
      if (byteDone) begin
        unique case (state_q)
          S_OP: begin
            opcode_q <= byteIn;
            state_q  <= decodeOp(byteIn, busy, wel_q, seq_q);
          end
          S_ADDR: begin
            addr_q    <= {addr_q[11:0], byteIn};
            addrCnt_q <= addrCnt_q + 2'h1;
            if (addrCnt_q == 2'h2) begin
              state_q <= afterAddr(opcode_q);
            end
          end
          S_DUMMY: state_q <= S_RDATA;
          S_PDATA: begin
            // The slot index keeps turning after the count saturates, so each
            // byte beyond a full page overwrites the oldest one.
            wrIdx_q <= wrIdx_q + 8'h01;
            if (dataCnt_q != sfp_pkg::PAGE_FULL) begin
              dataCnt_q <= dataCnt_q + 9'h001;
            end
          end
          S_ARG: begin
            argData_q <= byteIn;
            argGot_q  <= 1'b1;
          end
          S_RDATA, S_STAT, S_DONE, S_IGN: begin
          end
        endcase
      end
    end else if (sckFall && (state_q == S_RDATA || state_q == S_STAT)) begin
      outBit_q <= outBit_q + 3'h1;
      if (outBit_q == 3'h0) begin
        so_q    <= loadByte[7];
        outSh_q <= loadByte[6:0];
        if (state_q == S_RDATA) begin
          addr_q <= addr_q + 20'h00001;
        end
      end else begin
        so_q    <= outSh_q[6];
        outSh_q <= {outSh_q[5:0], 1'b0};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      soOe_q <= 1'b0;
    end else begin
      soOe_q <= !csF && (state_q == S_RDATA || state_q == S_STAT);
    end
  end

  // ==========================================================================
  // Page buffer
  // No reset: stale bytes are never programmed because only the received
  // count is written back.
  always_ff @(posedge ref_clk) begin
    if (byteDone && state_q == S_PDATA) begin
      pageBuf[bufIdx] <= byteIn;
    end
  end

  // ==========================================================================
  // Self-timed program engine
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      engState_q <= P_IDLE;
      page_q     <= 12'h000;
      progIdx_q  <= 8'h00;
      progLeft_q <= 9'h000;
      waitCnt_q  <= '0;
    end else begin
      unique case (engState_q)
        P_IDLE: begin
          if (progStart) begin
            engState_q <= P_WRITE;
            page_q     <= addr_q[19:8];
            progIdx_q  <= addr_q[7:0];
            progLeft_q <= dataCnt_q;
          end
        end
        P_WRITE:  engState_q <= P_HOLD;
        P_HOLD:   engState_q <= P_SETTLE;
        P_SETTLE: engState_q <= P_CHECK;
        P_CHECK: begin
          progIdx_q  <= progIdx_q + 8'h01;
          progLeft_q <= progLeft_q - 9'h001;
          if (progLeft_q == 9'h001) begin
            engState_q <= P_WAIT;
            waitCnt_q  <= WAIT_W'(PROG_WAIT_CYCLES - 1);
          end else begin
            engState_q <= P_WRITE;
          end
        end
        P_WAIT: begin
          if (waitCnt_q == '0) begin
            engState_q <= P_IDLE;
          end else begin
            waitCnt_q <= waitCnt_q - WAIT_W'(1);
          end
        end
      endcase
    end
  end

  // The read port is shared: while programming it points at the byte under
  // verification, so array reads are refused until the engine is idle.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      memAddr_q   <= 20'h00000;
      memWrEn_q   <= 1'b0;
      memWrData_q <= 8'h00;
    end else begin
      memWrEn_q <= (engState_q == P_WRITE);
      if (engState_q == P_IDLE) begin
        memAddr_q <= addr_q;
      end else if (engState_q == P_WRITE) begin
        memAddr_q   <= {page_q, progIdx_q};
        memWrData_q <= pageBuf[progIdx_q];
      end
    end
  end

  // ==========================================================================
  // Status flags
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      err_q <= 1'b0;
    end else if (engState_q == P_CHECK && memRdData != memWrData_q) begin
      err_q <= 1'b1;
    end else if (progStart) begin
      err_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wel_q <= 1'b0;
    end else if (progAbort || (engState_q == P_CHECK && progLeft_q == 9'h001)) begin
      wel_q <= 1'b0;
    end else if (cmdOk && opcode_q == sfp_pkg::OP_WREN) begin
      wel_q <= 1'b1;
    end else if (cmdOk && opcode_q == sfp_pkg::OP_WRDI) begin
      wel_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      seq_q <= 1'b0;
    end else if (cmdOk && opcode_q == sfp_pkg::OP_WRDI) begin
      seq_q <= 1'b0;
    end else if (cmdOk && (opcode_q == sfp_pkg::OP_SEQ_A || opcode_q == sfp_pkg::OP_SEQ_B)) begin
      seq_q <= 1'b1;
    end
  end

  // ==========================================================================
  // Forwarded commands
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cmdStrobe_q <= 1'b0;
      cmdOpcode_q <= 8'h00;
      cmdAddr_q   <= 20'h00000;
      cmdData_q   <= 8'h00;
    end else begin
      cmdStrobe_q <= cmdOk && opcode_q != sfp_pkg::OP_WREN
                     && opcode_q != sfp_pkg::OP_WRDI;
      if (cmdOk) begin
        cmdOpcode_q <= opcode_q;
        cmdAddr_q   <= addr_q;
        cmdData_q   <= argData_q;
      end
    end
  end

  assign so               = so_q;
  assign soOe             = soOe_q;
  assign memAddr          = memAddr_q;
  assign memWrEn          = memWrEn_q;
  assign memWrData        = memWrData_q;
  assign cmdStrobe        = cmdStrobe_q;
  assign cmdOpcode        = cmdOpcode_q;
  assign cmdAddr          = cmdAddr_q;
  assign cmdData          = cmdData_q;
  assign writeLatchFlag   = wel_q;
  assign programErrorFlag = err_q;
  assign seqMode          = seq_q;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  property p_cs_hiz;
    csRise |=> !soOe;
  endproperty
  a_cs_hiz: assert property (p_cs_hiz) else $error("output not released");

  property p_prog_needs_latch;
    $rose(busy) |-> $past(writeLatchFlag);
  endproperty
  a_prog_needs_latch: assert property (p_prog_needs_latch) else $error("program w/o latch");

  property p_abort_clears;
    progAbort |=> !writeLatchFlag && !busy;
  endproperty
  a_abort_clears: assert property (p_abort_clears) else $error("abort kept latch");

  property p_partial_byte;
    (csRise && bitIdx_q != 3'h0 && !busy) |=> !busy;
  endproperty
  a_partial_byte: assert property (p_partial_byte) else $error("partial byte programmed");

  property p_protected;
    (csRise && protHit && isProg && !busy) |=> !busy;
  endproperty
  a_protected: assert property (p_protected) else $error("protected page programmed");

  property p_read_wrap;
    (sckFall && state_q == S_RDATA && outBit_q == 3'h0 && addr_q == sfp_pkg::ADDR_TOP)
      |=> addr_q == 20'h00000;
  endproperty
  a_read_wrap: assert property (p_read_wrap) else $error("read did not wrap");

  property p_in_page;
    memWrEn |-> memAddr[19:8] == page_q;
  endproperty
  a_in_page: assert property (p_in_page) else $error("write left the page");

  property p_latch_before_done;
    $fell(busy) |-> !writeLatchFlag;
  endproperty
  a_latch_before_done: assert property (p_latch_before_done) else $error("latch set at end");

  property p_verify_error;
    (engState_q == P_CHECK && memRdData != memWrData) |=> programErrorFlag;
  endproperty
  a_verify_error: assert property (p_verify_error) else $error("error not flagged");

  property p_fast_read;
    (byteDone && state_q == S_OP && byteIn == sfp_pkg::OP_READ_FAST && !busy)
      |=> state_q == S_ADDR;
  endproperty
  a_fast_read: assert property (p_fast_read) else $error("fast read not decoded");

  property p_ignore;
    (state_q == S_IGN && !csF) |=> state_q == S_IGN && !soOe;
  endproperty
  a_ignore: assert property (p_ignore) else $error("ignored frame acted");

  property p_busy_run;
    progStart |=> busy [*4] ##1 memWrEn == 1'b0;
  endproperty
  a_busy_run: assert property (p_busy_run) else $error("program cycle cut short");

  c_read_wrap: cover property (sckFall && state_q == S_RDATA && addr_q == sfp_pkg::ADDR_TOP);
  c_prog_start: cover property (progStart && dataCnt_q == sfp_pkg::PAGE_FULL);
  c_prog_abort: cover property (progAbort);
  c_status_poll: cover property (busy && soOe && state_q == S_STAT);

endmodule
`default_nettype wire

// ==== verif/sfp_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ====================================================================
// Serial link master, mode 0: sck rests low between frames.
module sfp_host_model (
  // Clock
  input  wire logic ref_clk,
  // Link
  input  wire logic so,
  input  wire logic soOe,
  output logic      csN,
  output logic      sck,
  output logic      si
);
  initial begin
    csN = 1'b1;
    sck = 1'b0;
    si  = 1'b0;
  end

  task automatic waitCyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Each bit is 16 cycles low then 16 high, so si never moves near a rise.
  task automatic xferBits(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      si = tx[i];
      waitCyc(16);
      rx[i] = soOe ? so : 1'bz;
      sck = 1'b1;
      waitCyc(16);
      sck = 1'b0;
    end
  endtask

  task automatic frameBegin();
    csN = 1'b0;
    waitCyc(8);
  endtask

  // A released si shows the inverse of its last bit, never a stale copy.
  task automatic frameEnd();
    waitCyc(4);
    csN = 1'b1;
    si  = ~si;
    waitCyc(12);
  endtask
endmodule
`default_nettype wire

// ==== verif/sfp_port_test.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module sfp_port_test;
  logic        ref_clk, sys_rst, csN, sck, si, so, soOe, memWrEn, protHit;
  logic        cmdStrobe, busy, writeLatchFlag, programErrorFlag, seqMode;
  logic [19:0] memAddr, cmdAddr, base;
  logic [19:0] stuckAddr = 20'h00400;
  logic [11:0] pg;
  logic [7:0]  memRdData, memWrData, cmdOpcode, cmdData, b, r;
  logic [7:0]  mem [0:1048575];
  logic [7:0]  rxQ[$], txQ[$], dq[$];
  logic [7:0]  opsQ[$] = '{8'h20, 8'h52, 8'hD8, 8'h36, 8'h39, 8'h3C, 8'hAD,
                           8'h9F, 8'hB9, 8'hAB, 8'h60, 8'hC7, 8'hAF, 8'h01};
  logic [15:0] lfsrState = 16'h81A3;
  int          fail_count, tests_run, n, h, cnt;
  int          strobeCnt = 0;

  sfp_port #(.PROG_WAIT_CYCLES(4)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .csN(csN),
    .sck(sck), .si(si), .so(so), .soOe(soOe), .memAddr(memAddr), .memRdData(memRdData),
    .memWrEn(memWrEn), .memWrData(memWrData), .protHit(protHit), .cmdStrobe(cmdStrobe),
    .cmdOpcode(cmdOpcode), .cmdAddr(cmdAddr), .cmdData(cmdData), .busy(busy),
    .writeLatchFlag(writeLatchFlag), .programErrorFlag(programErrorFlag), .seqMode(seqMode));
  sfp_host_model host (.ref_clk(ref_clk), .so(so), .soOe(soOe), .csN(csN), .sck(sck), .si(si));

  // ====================================================================
  // Array model: one stuck byte never takes a write, to provoke a verify error.
  assign protHit = (memAddr[19:12] == 8'h80);
  always @(posedge ref_clk) begin
    memRdData <= mem[memAddr];
    if (memWrEn && memAddr != stuckAddr) mem[memAddr] <= memWrData;
    if (cmdStrobe) strobeCnt <= strobeCnt + 1;
  end
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ====================================================================
  // Helpers
  function automatic logic [7:0] rndByte();
    lfsrState = {lfsrState[14:0], lfsrState[15] ^ lfsrState[13] ^ lfsrState[12] ^ lfsrState[10]};
    return lfsrState[7:0];
  endfunction
  // Buffer slot k holds the latest byte whose position is k modulo 256.
  function automatic logic [7:0] pageExp(int k);
    return dq[k + (dq.size() - 1 - k) / 256 * 256];
  endfunction
  task automatic frame(input int partial);
    logic [7:0] v;
    rxQ.delete();
    host.frameBegin();
    foreach (txQ[i]) begin
      host.xferBits(txQ[i], (i == txQ.size() - 1 && partial > 0) ? partial : 8, v);
      rxQ.push_back(v);
    end
    host.frameEnd();
  endtask
  task automatic wren();
    txQ = '{sfp_pkg::OP_WREN};
    frame(0);
  endtask
  task automatic waitIdle();
    int k = 0;
    while (busy !== 1'b0 && k < 3000) begin
      host.waitCyc(1);
      k++;
    end
    `CHK(busy, 1'b0)
  endtask
  task automatic endTest(input string s);
    $display("test %s done: %0d checks, %0d mismatches", s, tests_run, fail_count);
  endtask
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ====================================================================
  // Scenarios
  initial begin
    sys_rst = 1'b1;
    for (int i = 0; i < 1048576; i++) mem[i] = 8'hFF;
    repeat (12) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    host.waitCyc(8);
    `CHK({busy, writeLatchFlag, programErrorFlag, seqMode, soOe}, 5'h00)
    txQ = '{8'h02, 8'h00, 8'h10, 8'h00, 8'hAB};
    frame(0);
    host.waitCyc(20);
    `CHK(mem[20'h01000], 8'hFF)
    wren();
    `CHK(writeLatchFlag, 1'b1)
    endTest("latch");
    b = rndByte();
    pg = {5'h01, b[6:0]};
    base = {pg, 8'h00};
    dq = '{rndByte(), rndByte(), rndByte()};
    txQ = '{sfp_pkg::OP_PAGE_PROG, {4'hF, pg[11:8]}, pg[7:0], 8'hFE};
    txQ = {txQ, dq};
    frame(0);
    waitIdle();
    `CHK(mem[base + 20'hFE], dq[0])
    `CHK(mem[base + 20'hFF], dq[1])
    `CHK(mem[base], dq[2])
    `CHK(mem[base + 20'h01], 8'hFF)
    `CHK(writeLatchFlag, 1'b0)
    endTest("wrap");
    wren();
    b = rndByte();
    pg = {5'h02, b[6:0]};
    dq.delete();
    for (int i = 0; i < 258; i++) dq.push_back(rndByte());
    txQ = '{sfp_pkg::OP_PAGE_PROG, {4'h0, pg[11:8]}, pg[7:0], 8'h00};
    txQ = {txQ, dq};
    frame(0);
    `CHK(busy, 1'b1)
    host.frameBegin();
    host.xferBits(sfp_pkg::OP_STATUS_RD, 8, r);
    host.xferBits(8'h00, 8, r);
    `CHK(r, 8'h03)
    n = 0;
    while (r[0] !== 1'b0 && n < 8) begin
      host.xferBits(8'h00, 8, r);
      n++;
    end
    `CHK(r, 8'h00)
    host.frameEnd();
    for (int k = 0; k < 256; k++) `CHK(mem[{pg, k[7:0]}], pageExp(k))
    endTest("page");
    for (int j = 0; j < 2; j++) begin
      mem[20'hFFFFE] = rndByte();
      mem[20'hFFFFF] = rndByte();
      mem[20'h00000] = rndByte();
      txQ = '{j ? sfp_pkg::OP_READ_FAST : sfp_pkg::OP_READ_SLOW, 8'hAF, 8'hFF, 8'hFE};
      if (j) txQ.push_back(8'h5C);
      repeat (4) txQ.push_back(8'h00);
      frame(3);
      h = txQ.size() - 4;
      `CHK(rxQ[h], mem[20'hFFFFE])
      `CHK(rxQ[h + 1], mem[20'hFFFFF])
      `CHK(rxQ[h + 2], mem[20'h00000])
      `CHK(soOe, 1'b0)
    end
    endTest("read");
    for (int j = 0; j < 4; j++) begin
      wren();
      txQ = '{sfp_pkg::OP_PAGE_PROG, 8'h00, 8'h03, 8'h20, 8'h77};
      if (j == 0) txQ = txQ[0:2];
      if (j == 2) txQ[1] = 8'h08;
      if (j == 3) txQ = txQ[0:3];
      frame(j == 1 ? 5 : 0);
      host.waitCyc(40);
      `CHK(writeLatchFlag, 1'b0)
      `CHK({busy, mem[20'h00320], mem[20'h80320]}, 17'h0FFFF)
    end
    endTest("abort");
    foreach (opsQ[j]) begin
      if (j < 3 || opsQ[j] inside {8'h60, 8'hC7, 8'hAD}) wren();
      cnt = strobeCnt;
      b = rndByte();
      txQ = '{opsQ[j]};
      if (j < 7) txQ = {txQ, 8'h01, b, 8'h44};
      if (opsQ[j] inside {8'h01, 8'hAD, 8'hAF}) txQ.push_back(b);
      frame(0);
      `CHK(strobeCnt, cnt + 1)
      `CHK(cmdOpcode, opsQ[j])
      if (j < 7) `CHK(cmdAddr, {4'h1, b, 8'h44})
    end
    `CHK(cmdData, b)
    `CHK(seqMode, 1'b1)
    // A reset in mid-run must leave sequential mode and drop the latch.
    sys_rst = 1'b1;
    host.waitCyc(12);
    sys_rst = 1'b0;
    host.waitCyc(8);
    `CHK({seqMode, writeLatchFlag, busy}, 3'h0)
    wren();
    txQ = '{sfp_pkg::OP_WRDI};
    frame(0);
    `CHK(writeLatchFlag, 1'b0)
    wren();
    cnt = strobeCnt;
    txQ = '{8'hFF, 8'h02, 8'h00, 8'h05, 8'h00, 8'h11};
    frame(0);
    host.waitCyc(20);
    `CHK(strobeCnt, cnt)
    `CHK({writeLatchFlag, mem[20'h00500]}, 9'h1FF)
    endTest("commands");
    txQ = '{sfp_pkg::OP_PAGE_PROG, 8'h00, 8'h04, 8'h00, 8'h5A};
    frame(0);
    waitIdle();
    `CHK(programErrorFlag, 1'b1)
    endTest("error");
    stop_test();
  end

  // A full run takes roughly 100k cycles; twice that means a hang.
  initial begin
    repeat (200000) @(posedge ref_clk);
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire
